// >>> src/fsq_pkg.sv
// Purpose: Shared constants and types for the flash self-write sequencer.
// Assumes: One 100 MHz system clock, synchronous active-low reset.
// Notes:   Register selects are indices on the core's special-register port.
// Functional notes
// - Program memory is rows of 14-bit words; a row is the smallest erase unit.
// - After a row erase, all or only some words of that row may be programmed.
// - Row data goes first into hidden 14-bit latches, loaded one by one via data regs.
// - Unprogrammed words may be programmed without erase; programmed words stay intact.
// - A row program covers 32 latches; row start address has low five bits zero.
// - With latch-only mode set, a write updates just the addressed latch, no programming.
// - With latch-only mode clear, a write loads the latch then programs all latches.
// - With erase select set, latch-only mode is ignored and a row erase happens.
// - Commands act only after 55h then AAh to unlock register, then write trigger.
// - After the write trigger the core executes two forced no-operation slots.
// - During array programming the core stalls after those slots until completion.
// - Read and write triggers can only be set by software; hardware clears them.
// - Writes and erases happen only with program enable set; it is clear after reset.
// - A reset during a program or erase sets the program error flag.
// - The unlock register is write-only and always reads as zero.
package fsq_pkg;
    localparam int unsigned WORD_W = 14;
    localparam int unsigned ROW_WORDS = 32;
    localparam int unsigned ROW_IDX_W = 5;
    localparam int unsigned FULL_ADDR_W = 15;

    // ------------------------------------------------------------
    // Register selects
    // ------------------------------------------------------------
    localparam logic [2:0] SEL_CTRL = 3'h0;
    localparam logic [2:0] SEL_UNLOCK = 3'h1;
    localparam logic [2:0] SEL_DATA_LO = 3'h2;
    localparam logic [2:0] SEL_DATA_HI = 3'h3;
    localparam logic [2:0] SEL_ADDR_LO = 3'h4;
    localparam logic [2:0] SEL_ADDR_HI = 3'h5;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int unsigned BIT_CFG_SEL = 6;
    localparam int unsigned BIT_LATCH_ONLY = 5;
    localparam int unsigned BIT_FREE = 4;
    localparam int unsigned BIT_ERR = 3;
    localparam int unsigned BIT_PROG_EN = 2;
    localparam int unsigned BIT_WR = 1;
    localparam int unsigned BIT_RD = 0;

    localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
    localparam logic [7:0] UNLOCK_KEY2 = 8'haa;
    localparam logic [13:0] ERASED_WORD = 14'h3fff;

    // ------------------------------------------------------------
    // Config space word indices
    // ------------------------------------------------------------
    localparam logic [3:0] CFG_DEVID_IDX = 4'h6;
    localparam logic [3:0] CFG_WORD1_IDX = 4'h7;
    localparam logic [3:0] CFG_WORD2_IDX = 4'h8;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned T_PROG_NS = 2000;
    localparam int unsigned PROG_CYCLES = (T_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned TIMER_W = 8;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] sel;
        logic [7:0] wdata;
    } fsq_sfr_req_s;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_NOP1,
        ST_NOP2,
        ST_ROW,
        ST_WAIT,
        ST_READ
    } fsq_state_e;
endpackage : fsq_pkg

// >>> src/fsq_prog_mem.sv
// Purpose: Program memory array with registered read data.
// Assumes: One access per cycle; write and read share the address.
// Notes:   And-mode write models flash programming, which can only clear bits.
module fsq_prog_mem #(
    parameter int unsigned AW = 11,
    parameter int unsigned DW = 14
) (
    input wire logic mclk_i,
    input wire logic ce_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic we_i,
    input wire logic and_mode_i,
    input wire logic [DW-1:0] wdata_i,
    output logic [DW-1:0] rdata_o
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge mclk_i) begin
        if (ce_i) begin
            if (we_i) begin
                // Erased cells hold ones, so and-mode keeps programmed words intact
                mem[addr_i] <= and_mode_i ? (mem[addr_i] & wdata_i) : wdata_i;
            end
            rdata_o <= mem[addr_i];
        end
    end
endmodule : fsq_prog_mem

// >>> src/fsq_flash_sequencer.sv
// Purpose: Self-write sequencer for on-chip program flash, driven by the core.
// Assumes: Core register accesses arrive on the system clock; one slot per cycle.
// Notes:   Row operations run word by word during the core stall, then a timer.
module fsq_flash_sequencer #(
    parameter int unsigned AW = 11,
    parameter logic [13:0] DEVICE_ID = 14'h0a5a, // Arbitrary identity value
    parameter logic [13:0] USER_ID = 14'h3fff,
    parameter logic [13:0] CONFIG_WORD1 = 14'h3fff,
    parameter logic [13:0] CONFIG_WORD2 = 14'h3fff
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire fsq_pkg::fsq_sfr_req_s sfr_req_i,
    output logic [7:0] sfr_rdata_o,
    output logic core_nop_o,
    output logic core_stall_o
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    fsq_pkg::fsq_state_e state_reg, state_next;
    logic cfg_sel_reg, cfg_sel_next, latch_only_reg, latch_only_next, free_reg, free_next;
    logic err_reg, err_next, prog_en_reg, prog_en_next, wr_reg, wr_next, rd_reg, rd_next;
    logic [1:0] unlock_reg, unlock_next;
    logic [14:0] addr_reg, addr_next;
    logic [13:0] data_reg, data_next;
    logic [13:0] latch_reg [0:31];
    logic [13:0] latch_next [0:31];
    logic [4:0] idx_reg, idx_next;
    logic [7:0] timer_reg, timer_next;
    logic [7:0] rdata_next;
    logic nop_next, stall_next;
    logic latch_load, latch_clear, trigger, op_busy;
    logic [AW-1:0] mem_addr;
    logic mem_we, mem_and;
    logic [13:0] mem_wdata, mem_dout, cfg_word;

    fsq_prog_mem #(.AW(AW), .DW(fsq_pkg::WORD_W)) u_mem (
        .mclk_i(mclk_i),
        .ce_i(ce_i),
        .addr_i(mem_addr),
        .we_i(mem_we),
        .and_mode_i(mem_and),
        .wdata_i(mem_wdata),
        .rdata_o(mem_dout)
    );

    // ------------------------------------------------------------
    // Config space words
    // ------------------------------------------------------------
    always_comb begin
        unique case (addr_reg[3:0])
            4'h0, 4'h1, 4'h2, 4'h3: cfg_word = USER_ID;
            fsq_pkg::CFG_DEVID_IDX: cfg_word = DEVICE_ID;
            fsq_pkg::CFG_WORD1_IDX: cfg_word = CONFIG_WORD1;
            fsq_pkg::CFG_WORD2_IDX: cfg_word = CONFIG_WORD2;
            default: cfg_word = 14'h0000;
        endcase
    end

    // ------------------------------------------------------------
    // Write latches, one per word of a row
    // ------------------------------------------------------------
    generate
        for (genvar g = 0; g < 32; g++) begin : g_latch
            always_comb begin
                latch_next[g] = latch_reg[g];
                if (latch_clear) begin
                    latch_next[g] = fsq_pkg::ERASED_WORD;
                end else if (latch_load && addr_reg[4:0] == 5'(g)) begin
                    latch_next[g] = data_reg;
                end
            end
            always_ff @(posedge mclk_i) begin
                if (!rst_n_i) begin
                    latch_reg[g] <= fsq_pkg::ERASED_WORD;
                end else if (ce_i) begin
                    latch_reg[g] <= latch_next[g];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Registers and sequencer
    // ------------------------------------------------------------
    assign op_busy = wr_reg && (free_reg || !latch_only_reg);

    always_comb begin
        state_next = state_reg;
        cfg_sel_next = cfg_sel_reg;
        latch_only_next = latch_only_reg;
        free_next = free_reg;
        err_next = err_reg;
        prog_en_next = prog_en_reg;
        wr_next = wr_reg;
        rd_next = rd_reg;
        unlock_next = unlock_reg;
        addr_next = addr_reg;
        data_next = data_reg;
        idx_next = idx_reg;
        timer_next = timer_reg;
        rdata_next = sfr_rdata_o;
        latch_load = 1'b0;
        latch_clear = 1'b0;
        trigger = 1'b0;
        mem_addr = addr_reg[AW-1:0];
        mem_we = 1'b0;
        mem_and = 1'b0;
        mem_wdata = fsq_pkg::ERASED_WORD;

        if (sfr_req_i.rd) begin
            unique case (sfr_req_i.sel)
                fsq_pkg::SEL_CTRL: rdata_next = {1'b1, cfg_sel_reg, latch_only_reg, free_reg,
                                                 err_reg, prog_en_reg, wr_reg, rd_reg};
                fsq_pkg::SEL_DATA_LO: rdata_next = data_reg[7:0];
                fsq_pkg::SEL_DATA_HI: rdata_next = {2'b00, data_reg[13:8]};
                fsq_pkg::SEL_ADDR_LO: rdata_next = addr_reg[7:0];
                fsq_pkg::SEL_ADDR_HI: rdata_next = {1'b0, addr_reg[14:8]};
                default: rdata_next = 8'h00;
            endcase
        end

        if (sfr_req_i.wr) begin
            // Any write other than the next key breaks the unlock sequence
            unlock_next = 2'd0;
            unique case (sfr_req_i.sel)
                fsq_pkg::SEL_UNLOCK: begin
                    if (sfr_req_i.wdata == fsq_pkg::UNLOCK_KEY1) begin
                        unlock_next = 2'd1;
                    end else if (unlock_reg == 2'd1
                                 && sfr_req_i.wdata == fsq_pkg::UNLOCK_KEY2) begin
                        unlock_next = 2'd2;
                    end
                end
                fsq_pkg::SEL_CTRL: begin
                    cfg_sel_next = sfr_req_i.wdata[fsq_pkg::BIT_CFG_SEL];
                    latch_only_next = sfr_req_i.wdata[fsq_pkg::BIT_LATCH_ONLY];
                    prog_en_next = sfr_req_i.wdata[fsq_pkg::BIT_PROG_EN];
                    if (state_reg == fsq_pkg::ST_IDLE) begin
                        free_next = sfr_req_i.wdata[fsq_pkg::BIT_FREE];
                        err_next = sfr_req_i.wdata[fsq_pkg::BIT_ERR];
                        if (sfr_req_i.wdata[fsq_pkg::BIT_RD]) begin
                            rd_next = 1'b1;
                            state_next = fsq_pkg::ST_READ;
                        end else if (sfr_req_i.wdata[fsq_pkg::BIT_WR] && unlock_reg == 2'd2
                                     && sfr_req_i.wdata[fsq_pkg::BIT_PROG_EN]) begin
                            trigger = 1'b1;
                        end
                    end
                end
                fsq_pkg::SEL_DATA_LO: data_next[7:0] = sfr_req_i.wdata;
                fsq_pkg::SEL_DATA_HI: data_next[13:8] = sfr_req_i.wdata[5:0];
                fsq_pkg::SEL_ADDR_LO: addr_next[7:0] = sfr_req_i.wdata;
                fsq_pkg::SEL_ADDR_HI: addr_next[14:8] = sfr_req_i.wdata[6:0];
                default: ;
            endcase
        end

        if (trigger) begin
            wr_next = 1'b1;
            err_next = 1'b0;
            // Erase select overrides latch-only mode and loads no latch
            latch_load = !sfr_req_i.wdata[fsq_pkg::BIT_FREE];
            state_next = fsq_pkg::ST_NOP1;
        end

        unique case (state_reg)
            fsq_pkg::ST_IDLE: ;
            fsq_pkg::ST_NOP1: state_next = fsq_pkg::ST_NOP2;
            fsq_pkg::ST_NOP2: begin
                idx_next = 5'd0;
                if (free_reg || !latch_only_reg) begin
                    state_next = fsq_pkg::ST_ROW;
                end else begin
                    wr_next = 1'b0;
                    state_next = fsq_pkg::ST_IDLE;
                end
            end
            fsq_pkg::ST_ROW: begin
                mem_addr = {addr_reg[AW-1:fsq_pkg::ROW_IDX_W], idx_reg};
                // Config space is not writable from this path
                mem_we = !cfg_sel_reg;
                mem_and = !free_reg;
                mem_wdata = free_reg ? fsq_pkg::ERASED_WORD : latch_reg[idx_reg];
                idx_next = idx_reg + 5'd1;
                if (idx_reg == 5'd31) begin
                    latch_clear = !free_reg;
                    timer_next = 8'(fsq_pkg::PROG_CYCLES - 1);
                    state_next = fsq_pkg::ST_WAIT;
                end
            end
            fsq_pkg::ST_WAIT: begin
                timer_next = timer_reg - 8'd1;
                if (timer_reg == 8'd0) begin
                    wr_next = 1'b0;
                    free_next = 1'b0;
                    state_next = fsq_pkg::ST_IDLE;
                end
            end
            fsq_pkg::ST_READ: begin
                data_next = cfg_sel_reg ? cfg_word : mem_dout;
                rd_next = 1'b0;
                state_next = fsq_pkg::ST_IDLE;
            end
            default: state_next = fsq_pkg::ST_IDLE;
        endcase

        nop_next = state_next == fsq_pkg::ST_NOP1 || state_next == fsq_pkg::ST_NOP2;
        stall_next = state_next == fsq_pkg::ST_ROW || state_next == fsq_pkg::ST_WAIT;
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state_reg <= fsq_pkg::ST_IDLE;
            cfg_sel_reg <= 1'b0;
            latch_only_reg <= 1'b0;
            free_reg <= 1'b0;
            // An interrupted program or erase leaves its mark across reset
            err_reg <= err_reg | op_busy;
            prog_en_reg <= 1'b0;
            wr_reg <= 1'b0;
            rd_reg <= 1'b0;
            unlock_reg <= 2'd0;
            addr_reg <= 15'h0000;
            data_reg <= 14'h0000;
            idx_reg <= 5'd0;
            timer_reg <= 8'h00;
            sfr_rdata_o <= 8'h00;
            core_nop_o <= 1'b0;
            core_stall_o <= 1'b0;
        end else if (ce_i) begin
            state_reg <= state_next;
            cfg_sel_reg <= cfg_sel_next;
            latch_only_reg <= latch_only_next;
            free_reg <= free_next;
            err_reg <= err_next;
            prog_en_reg <= prog_en_next;
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            unlock_reg <= unlock_next;
            addr_reg <= addr_next;
            data_reg <= data_next;
            idx_reg <= idx_next;
            timer_reg <= timer_next;
            sfr_rdata_o <= rdata_next;
            core_nop_o <= nop_next;
            core_stall_o <= stall_next;
        end
    end
endmodule : fsq_flash_sequencer

// >>> verif/fsq_flash_sequencer_sva.sv
// Purpose: Port-level checks for the flash self-write sequencer.
// Assumes: Clock enable held high while checked.
// Notes:   Bound to the design from the bench top.
module fsq_checker (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire fsq_pkg::fsq_sfr_req_s sfr_req_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic core_nop_o,
    input wire logic core_stall_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int STALL_LEN = fsq_pkg::ROW_WORDS + fsq_pkg::PROG_CYCLES;
    logic w_unl, w_ctl, key1, key2, trig, latch_only, erase;
    logic [8:0] stall_cnt_reg;
    logic [8:0] stall_cnt_next;
    assign w_unl = ce_i && sfr_req_i.wr && sfr_req_i.sel == fsq_pkg::SEL_UNLOCK;
    assign w_ctl = ce_i && sfr_req_i.wr && sfr_req_i.sel == fsq_pkg::SEL_CTRL;
    assign key1 = w_unl && sfr_req_i.wdata == fsq_pkg::UNLOCK_KEY1;
    assign key2 = w_unl && sfr_req_i.wdata == fsq_pkg::UNLOCK_KEY2;
    assign trig = w_ctl && sfr_req_i.wdata[fsq_pkg::BIT_WR];
    assign latch_only = sfr_req_i.wdata[fsq_pkg::BIT_LATCH_ONLY];
    assign erase = sfr_req_i.wdata[fsq_pkg::BIT_FREE];
    // Stall length counter; a long repetition would be too slow to unroll
    always_comb begin
        stall_cnt_next = core_stall_o ? stall_cnt_reg + 9'h001 : 9'h000;
    end
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            stall_cnt_reg <= 9'h000;
        end else begin
            stall_cnt_reg <= stall_cnt_next;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    sequence unlock_s;
        key1 ##1 key2 ##1 trig && sfr_req_i.wdata[fsq_pkg::BIT_PROG_EN]
            && !core_nop_o && !core_stall_o;
    endsequence
    sequence nop_pair_s;
        core_nop_o [*2] ##1 !core_nop_o;
    endsequence
    row_prog_a: assert property (
        unlock_s ##0 (!latch_only || erase) |=> nop_pair_s ##0 core_stall_o)
        else $error("row command did not stall after two nops");
    latch_only_a: assert property (
        unlock_s ##0 (latch_only && !erase) |=> nop_pair_s ##0 !core_stall_o ##1 !core_stall_o)
        else $error("latch-only command stalled");
    unlock_gate_a: assert property (
        $rose(core_nop_o) |-> $past(trig) && $past(key2, 2) && $past(key1, 3))
        else $error("nop without unlock and trigger");
    no_enable_a: assert property (
        key1 ##1 key2 ##1 trig && !sfr_req_i.wdata[fsq_pkg::BIT_PROG_EN] |=> !core_nop_o [*3])
        else $error("trigger accepted without program enable");
    nop_len_a: assert property ($rose(core_nop_o) |=> core_nop_o ##1 !core_nop_o)
        else $error("nop not two cycles");
    stall_start_a: assert property (
        $rose(core_stall_o) |-> $past(core_nop_o) && !core_nop_o)
        else $error("stall not right after nops");
    stall_len_a: assert property (
        $fell(core_stall_o) |-> stall_cnt_reg == STALL_LEN)
        else $error("stall length wrong");
    unlock_zero_a: assert property (
        ce_i && sfr_req_i.rd && sfr_req_i.sel == fsq_pkg::SEL_UNLOCK |=> sfr_rdata_o == 8'h00)
        else $error("unlock register read not zero");
endmodule : fsq_checker

// >>> verif/fsq_core_model.sv
// Purpose: Processor core model issuing register slots to the sequencer.
// Assumes: One access per cycle, launched at the falling edge.
// Notes:   Idle slots invert the data bus so stale values never match.
module fsq_core_model (
    input wire logic mclk_i,
    input wire logic [7:0] rdata_i,
    input wire logic nop_i,
    input wire logic stall_i,
    output fsq_pkg::fsq_sfr_req_s req_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial req_o = '0;
    task automatic put(input logic w, input logic r, input logic [2:0] s, input logic [7:0] d);
        @(negedge mclk_i);
        req_o <= {w, r, s, d};
    endtask : put
    task automatic idle(input int n);
        repeat (n) put(1'b0, 1'b0, req_o.sel, ~req_o.wdata);
    endtask : idle
    task automatic wr(input logic [2:0] s, input logic [7:0] d);
        put(1'b1, 1'b0, s, d);
    endtask : wr
    task automatic rd(input logic [2:0] s, output logic [7:0] d);
        put(1'b0, 1'b1, s, 8'h00);
        idle(1);
        d = rdata_i;
    endtask : rd
    // Interrupts are never modelled, so nothing breaks up the sequence
    task automatic trig(input logic [7:0] ctrl);
        wr(fsq_pkg::SEL_UNLOCK, fsq_pkg::UNLOCK_KEY1);
        wr(fsq_pkg::SEL_UNLOCK, fsq_pkg::UNLOCK_KEY2);
        wr(fsq_pkg::SEL_CTRL, ctrl);
    endtask : trig
    task automatic cmd(input logic [7:0] ctrl);
        trig(ctrl);
        idle(2);
        for (int i = 0; i < 300 && (nop_i || stall_i); i++) idle(1);
    endtask : cmd
endmodule : fsq_core_model

// >>> verif/test_fsq_flash_sequencer.sv
// Purpose: Self-checking bench for the flash self-write sequencer.
// Assumes: Clock enable held high; rows of 32 words at address bits 10:5.
// Notes:   Expected words follow from what the bench itself programmed.
module test_fsq_flash_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [13:0] DEV_ID = 14'h1234; // Arbitrary identity value
    localparam logic [13:0] CFG1 = 14'h2a5c;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic ce_i = 1'b1;
    fsq_pkg::fsq_sfr_req_s sfr_req_i;
    logic [7:0] sfr_rdata_o;
    logic core_nop_o;
    logic core_stall_o;
    int err_total = 0;
    int cmp_count = 0;
    logic [13:0] w;
    logic [7:0] v;
    fsq_flash_sequencer #(.DEVICE_ID(DEV_ID), .CONFIG_WORD1(CFG1)) DUT (.mclk_i(mclk_i),
        .rst_n_i(rst_n_i), .ce_i(ce_i), .sfr_req_i(sfr_req_i), .sfr_rdata_o(sfr_rdata_o),
        .core_nop_o(core_nop_o), .core_stall_o(core_stall_o));
    fsq_core_model core (.mclk_i(mclk_i), .rdata_i(sfr_rdata_o), .nop_i(core_nop_o),
        .stall_i(core_stall_o), .req_o(sfr_req_i));
    initial begin
        forever #5 mclk_i = ~mclk_i;
    end
    // ------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [13:0] seen, input logic [13:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic set_addr(input logic [14:0] a);
        core.wr(fsq_pkg::SEL_ADDR_LO, a[7:0]);
        core.wr(fsq_pkg::SEL_ADDR_HI, {1'b0, a[14:8]});
    endtask : set_addr
    task automatic rd_word(input logic [14:0] a, input logic cfg, output logic [13:0] d);
        logic [7:0] lo;
        logic [7:0] hi;
        set_addr(a);
        core.wr(fsq_pkg::SEL_CTRL, {1'b0, cfg, 6'h05});
        core.idle(2);
        core.rd(fsq_pkg::SEL_DATA_LO, lo);
        core.rd(fsq_pkg::SEL_DATA_HI, hi);
        d = {hi[5:0], lo};
    endtask : rd_word
    task automatic load(input logic [14:0] a, input logic [13:0] d, input logic [7:0] ctrl);
        set_addr(a);
        core.wr(fsq_pkg::SEL_DATA_LO, d[7:0]);
        core.wr(fsq_pkg::SEL_DATA_HI, {2'h0, d[13:8]});
        core.cmd(ctrl);
        // A command still busy here means the wait loop ran out
        chk({12'h000, core_nop_o, core_stall_o}, 14'h0000);
    endtask : load
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_values;
        core.rd(fsq_pkg::SEL_CTRL, v);
        chk({6'h00, v & 8'hf7}, 14'h0080);
        core.rd(fsq_pkg::SEL_UNLOCK, v);
        chk({6'h00, v}, 14'h0000);
    endtask : t_reset_values
    task automatic t_row_ops;
        // Partial rewrite: erase the row first, then reload the words to keep
        load(15'h0020, 14'h0000, 8'h36);
        core.rd(fsq_pkg::SEL_CTRL, v);
        chk({6'h00, v & 8'h13}, 14'h0000);
        rd_word(15'h0020, 1'b0, w);
        chk(w, 14'h3fff);
        rd_word(15'h003f, 1'b0, w);
        chk(w, 14'h3fff);
        load(15'h0020, 14'h1a5c, 8'h26);
        rd_word(15'h0020, 1'b0, w);
        chk(w, 14'h3fff);
        // Row started at a latch index of zero, then the next word programs the row
        load(15'h0021, 14'h2c31, 8'h06);
        core.rd(fsq_pkg::SEL_CTRL, v);
        chk({6'h00, v & 8'h03}, 14'h0000);
        rd_word(15'h0020, 1'b0, w);
        chk(w, 14'h1a5c);
        rd_word(15'h0021, 1'b0, w);
        chk(w, 14'h2c31);
        rd_word(15'h0022, 1'b0, w);
        chk(w, 14'h3fff);
        load(15'h0022, 14'h0f0f, 8'h06);
        rd_word(15'h0022, 1'b0, w);
        chk(w, 14'h0f0f);
        rd_word(15'h0020, 1'b0, w);
        chk(w, 14'h1a5c);
    endtask : t_row_ops
    task automatic t_refused;
        core.wr(fsq_pkg::SEL_UNLOCK, 8'h55);
        core.wr(fsq_pkg::SEL_DATA_LO, 8'h00);
        core.wr(fsq_pkg::SEL_UNLOCK, 8'haa);
        core.wr(fsq_pkg::SEL_CTRL, 8'h06);
        core.idle(3);
        core.rd(fsq_pkg::SEL_CTRL, v);
        chk({6'h00, v & 8'h02}, 14'h0000);
        load(15'h0023, 14'h0000, 8'h02);
        rd_word(15'h0023, 1'b0, w);
        chk(w, 14'h3fff);
    endtask : t_refused
    task automatic t_config;
        rd_word(15'h0006, 1'b1, w);
        chk(w, DEV_ID);
        rd_word(15'h0007, 1'b1, w);
        chk(w, CFG1);
        rd_word(15'h0020, 1'b0, w);
        chk(w, 14'h1a5c);
    endtask : t_config
    task automatic t_reset_err;
        set_addr(15'h0024);
        core.trig(8'h06);
        core.idle(20);
        rst_n_i = 1'b0;
        core.idle(2);
        rst_n_i = 1'b1;
        core.rd(fsq_pkg::SEL_CTRL, v);
        chk({6'h00, v & 8'h0a}, 14'h0008);
    endtask : t_reset_err
    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (6) @(negedge mclk_i);
        rst_n_i = 1'b1;
        t_reset_values();
        t_row_ops();
        t_refused();
        t_config();
        t_reset_err();
        report_and_stop();
    end
    // About 1000 cycles are expected; this allows some forty times that
    initial begin
        #400000;
        err_total++;
        report_and_stop();
    end
endmodule : test_fsq_flash_sequencer
bind fsq_flash_sequencer fsq_checker u_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .sfr_req_i(sfr_req_i), .sfr_rdata_o(sfr_rdata_o), .core_nop_o(core_nop_o),
    .core_stall_o(core_stall_o));
